// >>> inc/csf_pkg.sv
package csf_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CORE_CTRL = 4'h1;
    localparam logic [3:0] REG_INT_CTRL_ONE = 4'h2;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h3;
    localparam logic [3:0] REG_IRQ_MASK = 4'h4;
    localparam logic [3:0] REG_EFF_PRIORITY = 4'h5;

    // Status word field positions, plus the core control top bit and the nesting disable bit
    localparam int BIT_ACC_A_CLIP = 13;
    localparam int BIT_ACC_B_CLIP = 12;
    localparam int BIT_ACC_CLIP_COMBINED = 11;
    localparam int BIT_PRIO_HI = 7;
    localparam int BIT_PRIO_LO = 5;
    localparam int BIT_LOOP_RUNNING = 4;
    localparam int BIT_NEGATIVE = 3;
    localparam int BIT_SIGNED_WRAP = 2;
    localparam int BIT_ZERO = 1;
    localparam int BIT_CARRY = 0;
    localparam int BIT_PRIO_TOP = 3;
    localparam int BIT_NESTING_DISABLE = 15;

    localparam logic [2:0] PRIO_MAX = 3'h7;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] CORE_CTRL_RESET = 16'h0000;
    localparam logic [15:0] INT_CTRL_ONE_RESET = 16'h0000;

    // Interrupt event bits
    localparam int EV_WRAP = 0;
    localparam int EV_CARRY = 1;
    localparam int EV_LOOP_END = 2;
    localparam int EV_CLIP = 3;
    localparam int EV_WIDTH = 4;

    // Flag update from the execution unit
    typedef struct packed {
        logic valid;
        logic [15:0] result;
        logic carry;
        logic signedWrap;
        logic updNegative;
        logic updSignedWrap;
        logic updZero;
        logic updCarry;
    } csf_alu_s;

    typedef struct packed {
        logic accAClip;
        logic accBClip;
    } csf_clip_s;
endpackage

// >>> sim/csf_exec_unit.sv
`timescale 1ns/1ps
module csf_exec_unit (
    input wire logic doOp,
    input wire logic [15:0] opA,
    input wire logic [15:0] opB,
    input wire logic [3:0] updMask,
    output csf_pkg::csf_alu_s alu
);
    logic [16:0] sum;
    // Adder only: the flag paths do not care which op made the result
    always_comb begin
        sum = {1'b0, opA} + {1'b0, opB};
        alu.valid = doOp;
        alu.result = sum[15:0];
        alu.carry = sum[16];
        alu.signedWrap = (opA[15] == opB[15]) && (sum[15] != opA[15]);
        {alu.updNegative, alu.updSignedWrap, alu.updZero, alu.updCarry} = updMask;
    end
endmodule // csf_exec_unit

// >>> sim/csf_status_flags_properties.sv
`timescale 1ns/1ps
module csf_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire csf_pkg::csf_alu_s aluUpdate,
    input wire logic loopRunning,
    input wire logic [15:0] cpuStatusWord,
    input wire logic [3:0] effPriority,
    input wire logic userIrqBlocked
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire v = aluUpdate.valid;
    prio_field_a: assert property (effPriority[2:0] == cpuStatusWord[7:5])
        else $error("priority field");
    prio_top_a: assert property (effPriority[3] |-> userIrqBlocked)
        else $error("top bit not blocking");
    prio_seven_a: assert property (
        userIrqBlocked == (effPriority[3] || &cpuStatusWord[7:5]))
        else $error("block level");
    // Reset cycle excluded: bit is forced low there
    loop_flag_a: assert property (
        !$past(reset) |-> cpuStatusWord[4] == $past(loopRunning))
        else $error("loop flag");
    neg_flag_a: assert property (v && aluUpdate.updNegative |=>
        cpuStatusWord[3] == $past(aluUpdate.result[15])) else $error("negative");
    wrap_flag_a: assert property (v && aluUpdate.updSignedWrap |=>
        cpuStatusWord[2] == $past(aluUpdate.signedWrap)) else $error("wrap");
    zero_clear_a: assert property (
        v && aluUpdate.updZero && aluUpdate.result != 16'h0000 |=> !cpuStatusWord[1])
        else $error("zero");
    carry_flag_a: assert property (v && aluUpdate.updCarry |=>
        cpuStatusWord[0] == $past(aluUpdate.carry)) else $error("carry");
    carry_hold_a: assert property (v && !aluUpdate.updCarry &&
        !(regWrite && regAddr == csf_pkg::REG_STATUS) |=> $stable(cpuStatusWord[0]))
        else $error("carry moved");
endmodule // csf_chk
bind csf_status_flags csf_chk u_chk (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .aluUpdate(aluUpdate), .loopRunning(loopRunning),
    .cpuStatusWord(cpuStatusWord), .effPriority(effPriority), .userIrqBlocked(userIrqBlocked));

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk, reset, regWrite, regRead, doOp, loopRunning, userIrqBlocked, irq, nest;
    logic [3:0] regAddr, updMask, effPriority;
    logic [15:0] regWrData, regRdData, cpuStatusWord, opA, opB, es;
    logic [16:0] s;
    csf_pkg::csf_alu_s alu;
    csf_pkg::csf_clip_s clipSet;
    int fail_count, cmp_count, seed, i;
    csf_status_flags u_csf_status_flags (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .aluUpdate(alu), .clipSet(clipSet), .loopRunning(loopRunning), .irq(irq),
        .cpuStatusWord(cpuStatusWord), .effPriority(effPriority),
        .userIrqBlocked(userIrqBlocked));
    csf_exec_unit u_csf_exec_unit (.doOp(doOp), .opA(opA), .opB(opB), .updMask(updMask),
        .alu(alu));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task results;
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task edge_tick;
        @(posedge ref_clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask
    // Whole-word writes only, never bit operations on the clip flags
    task wst(input logic [15:0] d);
        wr(csf_pkg::REG_STATUS, d);
        es[3:0] = d[3:0];
        if (!nest) es[7:5] = d[7:5];
        es[13:12] = d[11] ? d[13:12] : 2'b00;
        es[11] = |es[13:12];
        chk(cpuStatusWord, es);
    endtask
    task op(input logic [15:0] a, input logic [15:0] b, input logic [3:0] m);
        @(posedge ref_clk);
        doOp <= 1'b1;
        opA <= a;
        opB <= b;
        updMask <= m;
        @(posedge ref_clk);
        doOp <= 1'b0;
        #1;
        s = {1'b0, a} + {1'b0, b};
        if (m[3]) es[3] = s[15];
        if (m[2]) es[2] = (a[15] == b[15]) && (s[15] != a[15]);
        if (m[1] && s[15:0] != 16'h0000) es[1] = 1'b0;
        if (m[0]) es[0] = s[16];
        chk(cpuStatusWord, es);
    endtask
    initial begin
        {seed, fail_count, cmp_count, es, nest} = {32'd66794, 64'd0, 17'h0};
        {reset, regWrite, regRead, regAddr, regWrData, doOp, loopRunning} = {1'b1, 24'h0};
        {opA, opB, updMask, clipSet} = '0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        for (i = 0; i < 6; i++) rd(i[3:0], 16'h0000);
        wr(4'hf, 16'hffff);
        rd(4'hf, 16'h0000);
        wst(16'hffff);
        chk({15'h0, userIrqBlocked}, 16'h0001);
        wr(csf_pkg::REG_CORE_CTRL, 16'h0008);
        chk({12'h0, effPriority}, 16'h000f);
        rd(csf_pkg::REG_EFF_PRIORITY, 16'h000f);
        wst(16'h0000);
        chk({15'h0, userIrqBlocked}, 16'h0001);
        wr(csf_pkg::REG_CORE_CTRL, 16'h0000);
        wr(csf_pkg::REG_INT_CTRL_ONE, 16'h8000);
        nest = 1'b1;
        wst(16'h38a0);
        wr(csf_pkg::REG_INT_CTRL_ONE, 16'h0000);
        nest = 1'b0;
        wst(16'h3002);
        op(16'h0001, 16'h0001, 4'h2);
        op(16'h7fff, 16'h0001, 4'hf);
        for (i = 0; i < 40; i++) begin
            op(16'($random(seed)), 16'($random(seed)), 4'($random(seed)));
        end
        wr(csf_pkg::REG_IRQ_STATUS, 16'h000f);
        wr(csf_pkg::REG_IRQ_MASK, 16'h0006);
        op(16'hffff, 16'h0001, 4'h1);
        chk({15'h0, irq}, 16'h0001);
        rd(csf_pkg::REG_IRQ_STATUS, 16'h0002);
        wr(csf_pkg::REG_IRQ_STATUS, 16'h0002);
        chk({15'h0, irq}, 16'h0000);
        loopRunning <= 1'b1;
        edge_tick();
        es[4] = 1'b1;
        chk(cpuStatusWord, es);
        loopRunning <= 1'b0;
        edge_tick();
        es[4] = 1'b0;
        chk(cpuStatusWord, es);
        chk({15'h0, irq}, 16'h0001);
        clipSet <= 2'b10;
        edge_tick();
        clipSet <= 2'b00;
        es[13] = 1'b1;
        es[11] = 1'b1;
        chk(cpuStatusWord, es);
        rd(csf_pkg::REG_STATUS, es);
        results();
    end
    initial begin
        #50000;
        fail_count++;
        results();
    end
endmodule // testbench

// >>> src/csf_status_flags.sv
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Status bits 7..5 hold the priority field, codes 0..7 meaning levels 0..7.
// - Priority field at 7 with the top priority bit clear blocks user interrupts.
// - Effective priority is the top bit from core control bit 3 over the field.
// - A set top priority bit blocks user interrupts whatever the field holds.
// - Software writes to the priority field are ignored while nesting disable is set.
// - Status bit 4 is high while a repeat loop runs, low otherwise.
// - Status bit 3 is set for a negative result and cleared otherwise.
// - Status bit 2 is set on signed overflow and cleared otherwise.
// - Status bit 1 is cleared by a non-zero result and may stay set until then.
// - Status bit 0 is set on carry out of the top bit and cleared otherwise.
// - A data write may change both clip flags directly or clear them via the combined bit.
module csf_status_flags (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    input wire csf_pkg::csf_alu_s aluUpdate,
    input wire csf_pkg::csf_clip_s clipSet,
    input wire logic loopRunning,
    output logic [15:0] cpuStatusWord,
    output logic [3:0] effPriority,
    output logic userIrqBlocked,
    output logic irq
);
    logic [15:0] status;
    logic [15:0] coreControl;
    logic [15:0] intControlOne;
    logic [3:0] irqStatus;
    logic [3:0] irqMask;
    logic prevLoop;
    logic [15:0] next_status;
    logic [15:0] next_coreControl;
    logic [15:0] next_intControlOne;
    logic [3:0] next_irqStatus;
    logic [3:0] next_irqMask;
    logic [15:0] next_regRdData;
    logic [3:0] next_effPriority;
    logic next_userIrqBlocked;
    logic next_irq;
    logic [3:0] events;

    function automatic logic hit(input logic [3:0] idx);
        hit = regWrite && (regAddr == idx);
    endfunction

    always_comb begin
        next_status = status;
        next_coreControl = coreControl;
        next_intControlOne = intControlOne;
        next_irqMask = irqMask;
        // Software write first so the hardware update below wins in the same cycle
        if (hit(csf_pkg::REG_STATUS)) begin
            if (!intControlOne[csf_pkg::BIT_NESTING_DISABLE]) begin
                next_status[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO] =
                    regWrData[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO];
            end
            next_status[csf_pkg::BIT_NEGATIVE:csf_pkg::BIT_CARRY] =
                regWrData[csf_pkg::BIT_NEGATIVE:csf_pkg::BIT_CARRY];
            next_status[csf_pkg::BIT_ACC_A_CLIP] = regWrData[csf_pkg::BIT_ACC_A_CLIP];
            next_status[csf_pkg::BIT_ACC_B_CLIP] = regWrData[csf_pkg::BIT_ACC_B_CLIP];
            if (!regWrData[csf_pkg::BIT_ACC_CLIP_COMBINED]) begin
                next_status[csf_pkg::BIT_ACC_A_CLIP] = 1'b0;
                next_status[csf_pkg::BIT_ACC_B_CLIP] = 1'b0;
            end
        end
        if (aluUpdate.valid) begin
            if (aluUpdate.updNegative) begin
                next_status[csf_pkg::BIT_NEGATIVE] = aluUpdate.result[15];
            end
            if (aluUpdate.updSignedWrap) begin
                next_status[csf_pkg::BIT_SIGNED_WRAP] = aluUpdate.signedWrap;
            end
            if (aluUpdate.updZero && (aluUpdate.result != 16'h0000)) begin
                // A zero result leaves the sticky zero flag alone
                next_status[csf_pkg::BIT_ZERO] = 1'b0;
            end
            if (aluUpdate.updCarry) begin
                next_status[csf_pkg::BIT_CARRY] = aluUpdate.carry;
            end
        end
        if (clipSet.accAClip) begin
            next_status[csf_pkg::BIT_ACC_A_CLIP] = 1'b1;
        end
        if (clipSet.accBClip) begin
            next_status[csf_pkg::BIT_ACC_B_CLIP] = 1'b1;
        end
        next_status[csf_pkg::BIT_LOOP_RUNNING] = loopRunning;
        next_status[csf_pkg::BIT_ACC_CLIP_COMBINED] =
            next_status[csf_pkg::BIT_ACC_A_CLIP] | next_status[csf_pkg::BIT_ACC_B_CLIP];
        if (hit(csf_pkg::REG_CORE_CTRL)) begin
            next_coreControl = regWrData;
        end
        if (hit(csf_pkg::REG_INT_CTRL_ONE)) begin
            next_intControlOne = regWrData;
        end
        if (hit(csf_pkg::REG_IRQ_MASK)) begin
            next_irqMask = regWrData[3:0];
        end
    end

    always_comb begin
        events = '0;
        events[csf_pkg::EV_WRAP] = aluUpdate.valid && aluUpdate.updSignedWrap
            && aluUpdate.signedWrap;
        events[csf_pkg::EV_CARRY] = aluUpdate.valid && aluUpdate.updCarry && aluUpdate.carry;
        events[csf_pkg::EV_LOOP_END] = prevLoop && !loopRunning;
        events[csf_pkg::EV_CLIP] = clipSet.accAClip || clipSet.accBClip;
        next_irqStatus = irqStatus;
        if (hit(csf_pkg::REG_IRQ_STATUS)) begin
            next_irqStatus = irqStatus & ~regWrData[3:0];
        end
        // Set beats clear in the same cycle
        next_irqStatus = next_irqStatus | events;
        next_irq = |(next_irqStatus & next_irqMask);
    end

    always_comb begin
        // Effective priority and blocking are built from the next state, so they change in the same cycle as the registered state
        next_effPriority = {next_coreControl[csf_pkg::BIT_PRIO_TOP],
            next_status[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO]};
        next_userIrqBlocked = next_coreControl[csf_pkg::BIT_PRIO_TOP]
            || (next_status[csf_pkg::BIT_PRIO_HI:csf_pkg::BIT_PRIO_LO]
                == csf_pkg::PRIO_MAX);
        next_regRdData = 16'h0000;
        if (regRead) begin
            unique case (regAddr)
                csf_pkg::REG_STATUS: next_regRdData = status;
                csf_pkg::REG_CORE_CTRL: next_regRdData = coreControl;
                csf_pkg::REG_INT_CTRL_ONE: next_regRdData = intControlOne;
                csf_pkg::REG_IRQ_STATUS: next_regRdData = {12'h000, irqStatus};
                csf_pkg::REG_IRQ_MASK: next_regRdData = {12'h000, irqMask};
                csf_pkg::REG_EFF_PRIORITY: next_regRdData = {12'h000, effPriority};
                default: next_regRdData = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status <= csf_pkg::STATUS_RESET;
            coreControl <= csf_pkg::CORE_CTRL_RESET;
            intControlOne <= csf_pkg::INT_CTRL_ONE_RESET;
            irqStatus <= '0;
            irqMask <= '0;
            prevLoop <= 1'b0;
            regRdData <= 16'h0000;
            cpuStatusWord <= csf_pkg::STATUS_RESET;
            effPriority <= 4'h0;
            userIrqBlocked <= 1'b0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            coreControl <= next_coreControl;
            intControlOne <= next_intControlOne;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            prevLoop <= loopRunning;
            regRdData <= next_regRdData;
            cpuStatusWord <= next_status;
            effPriority <= next_effPriority;
            userIrqBlocked <= next_userIrqBlocked;
            irq <= next_irq;
        end
    end
endmodule // csf_status_flags
